// >>> verilog/pulse_input_status_defines.vh
// Constants for the pulse input status and counting block.
// Assumes a 250 MHz system clock and a synchronous active-low reset.
`ifndef PULSE_INPUT_STATUS_DEFINES_VH
`define PULSE_INPUT_STATUS_DEFINES_VH

// ----------------------------------------
// Clock and input frequency range
// ----------------------------------------
`define CLK_HZ 250000000
`define CLK_NS 4
`define FREQ_MIN_HZ 5
`define FREQ_MAX_HZ 25000

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_INPUTS 10
`define NUM_GROUPS 5
`define TOTAL_W 16
`define PERIOD_W 26
`define PHASE_W 9
`define DEB_W 8
`define ID_W 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define DEBOUNCE_NS 1000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOST_TIMEOUT_MS 100
`define BLINK_HZ 2

// ----------------------------------------
// Duty and phase thresholds
// ----------------------------------------
`define DUTY_MIN_NUM 3
`define DUTY_MIN_DEN 20
`define COINC_DIV 32
`define FULL_TURN_DEG 360

// ----------------------------------------
// Reset values and identity
// ----------------------------------------
`define MODULE_IDENTIFIER_VALUE 8'h5a // Arbitrary value
`define TOTAL_RST 16'h0000
`define PERIOD_RST 26'h0000000

`endif

// >>> verilog/pulse_input_status_counter.v
// Pulse totalizer status and counting logic: ten debounced pulse inputs,
// pair checks, frequency classes, front indicators and a prover port.
// Assumes field pins are asynchronous; host-side controls share clk.
//
// Contract
// - Power light green when powered and initialized
// - Power light red when initialization failed
// - Power light off without power or hot-swap
// - Host light green while host reads periodically
// - Host light red when host access stops
// - Proving light blue only during proving
// - Failure light red on bus hardware failure
// - Input light green when within limits
// - Input light blinks between limits and range
// - Input light red outside range or narrow
// - Input light off when input disabled
// - Ten inputs, five groups, single or dual
// - Each input counts into 16-bit totalizer
// - Measure and report period for frequency
// - Debounce every input before counting
// - Prover: three inputs, one open-drain output
// - Counting never depends on host access
// - Reference meter group treated like others
// - Fixed module identifier readable by host
// - Per-type error counters; errors excluded
`timescale 1ns/1ps
`include "pulse_input_status_defines.vh"

module pulse_input_status_counter #(
  parameter MAX_PERIOD = `CLK_HZ / `FREQ_MIN_HZ,
  parameter MIN_PERIOD = `CLK_HZ / `FREQ_MAX_HZ,
  parameter HOST_TIMEOUT = (`CLK_HZ / 1000) * `HOST_TIMEOUT_MS,
  parameter BLINK_HALF = `CLK_HZ / (2 * `BLINK_HZ)
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Field pulse and prover pins
  input wire [9:0] pulse_in,
  input wire [2:0] prover_discrete_input,
  output reg prover_run_output,
  output reg prover_run_oe_n,
  // Power and health pins
  input wire bus_power_ok,
  input wire hot_swap_ok,
  input wire init_done,
  // Host-side controls from backplane_module_bus logic
  input wire host_access,
  input wire bus_fail,
  input wire proving_active,
  input wire prover_run_cmd,
  input wire [9:0] input_enable,
  input wire [4:0] dual_mode,
  input wire [25:0] low_freq_limit,
  input wire [25:0] high_freq_limit,
  input wire [8:0] phase_dif,
  input wire [8:0] phase_dev,
  // Counts and measurements
  output reg [159:0] total,
  output reg [259:0] period,
  output reg [79:0] seq_err_cnt,
  output reg [79:0] coinc_err_cnt,
  output reg [79:0] phase_err_cnt,
  output reg [79:0] extra_err_cnt,
  output reg [2:0] prover_in_state,
  output reg [7:0] module_identifier,
  // Front indicators
  output reg power_led_green,
  output reg power_led_red,
  output reg host_led_green,
  output reg host_led_red,
  output reg proving_indicator,
  output reg fail_led_red,
  output reg [9:0] input_led_green,
  output reg [9:0] input_led_red
);

  localparam [25:0] MAX_P = MAX_PERIOD[25:0];
  localparam [25:0] MIN_P = MIN_PERIOD[25:0];
  localparam [27:0] HOST_TO = HOST_TIMEOUT[27:0];
  localparam [25:0] BLINK_H = BLINK_HALF[25:0];
  localparam DEB_FULL = `DEBOUNCE_CYC;
  localparam [7:0] DEB_CYC = DEB_FULL[7:0];
  localparam NSYNC = 16;

  // Indicator classes, one-hot
  localparam [3:0] CL_OFF = 4'h1;
  localparam [3:0] CL_GREEN = 4'h2;
  localparam [3:0] CL_BLINK = 4'h4;
  localparam [3:0] CL_RED = 4'h8;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Class of one input from its measured period and high time
  function [3:0] classify;
    input en;
    input ok;
    input [25:0] p;
    input [25:0] hi;
    input [25:0] lo_lim;
    input [25:0] hi_lim;
    input [25:0] min_w;
    begin
      if (!en)
        classify = CL_OFF;
      else if (!ok || p > MAX_P || p < MIN_P || hi < min_w)
        classify = CL_RED;
      else if (p >= hi_lim && p <= lo_lim)
        classify = CL_GREEN;
      else
        classify = CL_BLINK;
    end
  endfunction

  // ----------------------------------------
  // Synchronisers for asynchronous pins
  // ----------------------------------------
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  wire [NSYNC-1:0] pins;

  assign pins = {hot_swap_ok, bus_power_ok, init_done,
                 prover_discrete_input, pulse_in};

  // Two flops ahead of any logic
  always @(posedge clk) begin
    if (!resetn) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  reg [12:0] deb_r;
  reg [12:0] deb_d_r;
  reg [7:0] deb_cnt_r [0:12];
  wire [12:0] rise;
  wire [12:0] fall;

  assign rise = deb_r & ~deb_d_r;
  assign fall = ~deb_r & deb_d_r;

  // Input must hold its new level for the debounce time
  always @(posedge clk) begin : debounce_proc
    integer k;
    for (k = 0; k < 13; k = k + 1) begin
      if (!resetn) begin
        deb_r[k] <= 1'b0;
        deb_cnt_r[k] <= 8'h00;
      end else if (sync2_r[k] == deb_r[k]) begin
        deb_cnt_r[k] <= 8'h00;
      end else if (deb_cnt_r[k] >= DEB_CYC - 8'h01) begin
        deb_r[k] <= sync2_r[k];
        deb_cnt_r[k] <= 8'h00;
      end else begin
        deb_cnt_r[k] <= deb_cnt_r[k] + 8'h01;
      end
    end
    if (!resetn)
      deb_d_r <= 13'h0000;
    else
      deb_d_r <= deb_r;
  end

  // ----------------------------------------
  // Period and high time measurement
  // ----------------------------------------
  reg [25:0] per_cnt_r [0:9];
  reg [25:0] hi_cnt_r [0:9];
  reg [25:0] hi_r [0:9];
  reg [9:0] alive_r;
  reg [9:0] seen_r;

  // Period latched rise to rise; a stall past 5 Hz drops alive
  always @(posedge clk) begin : period_proc
    integer k;
    for (k = 0; k < 10; k = k + 1) begin
      if (!resetn) begin
        per_cnt_r[k] <= `PERIOD_RST;
        hi_cnt_r[k] <= `PERIOD_RST;
        hi_r[k] <= `PERIOD_RST;
        period[k*26 +: 26] <= `PERIOD_RST;
        alive_r[k] <= 1'b0;
        seen_r[k] <= 1'b0;
      end else begin
        if (rise[k]) begin
          if (seen_r[k]) begin
            period[k*26 +: 26] <= per_cnt_r[k];
            alive_r[k] <= 1'b1;
          end
          seen_r[k] <= 1'b1;
          per_cnt_r[k] <= 26'h0000001;
          hi_cnt_r[k] <= 26'h0000001;
        end else begin
          if (per_cnt_r[k] > MAX_P) begin
            alive_r[k] <= 1'b0;
            seen_r[k] <= 1'b0;
          end else begin
            per_cnt_r[k] <= per_cnt_r[k] + 26'h0000001;
          end
          if (deb_r[k] && hi_cnt_r[k] <= MAX_P)
            hi_cnt_r[k] <= hi_cnt_r[k] + 26'h0000001;
        end
        if (fall[k])
          hi_r[k] <= hi_cnt_r[k];
      end
    end
  end

  // ----------------------------------------
  // Dual-signal phase classification
  // ----------------------------------------
  reg [4:0] a_pend_r;
  reg [25:0] dly_r [0:4];
  reg [4:0] coinc;
  reg [4:0] phase_bad;
  reg [39:0] dly_deg;
  reg [39:0] lo_deg;
  reg [39:0] hi_deg;
  reg [9:0] lo_ang;
  reg [9:0] hi_ang;

  // Coincident at or below a 32nd of a turn, else window on phase_dif
  always @* begin : phase_proc
    integer g;
    g = 0;
    coinc = 5'h00;
    phase_bad = 5'h00;
    dly_deg = 40'h0;
    lo_deg = 40'h0;
    hi_deg = 40'h0;
    lo_ang = 10'h000;
    hi_ang = 10'h000;
    for (g = 0; g < 5; g = g + 1) begin
      lo_ang = {1'b0, phase_dif} - {1'b0, phase_dev};
      if (phase_dev > phase_dif)
        lo_ang = 10'h000;
      hi_ang = {1'b0, phase_dif} + {1'b0, phase_dev};
      dly_deg = {14'h0, dly_r[g]} * `FULL_TURN_DEG;
      lo_deg = {14'h0, period[(2*g)*26 +: 26]} * {30'h0, lo_ang};
      hi_deg = {14'h0, period[(2*g)*26 +: 26]} * {30'h0, hi_ang};
      coinc[g] = ({9'h0, dly_r[g], 5'h00} <=
                  {14'h0, period[(2*g)*26 +: 26]});
      phase_bad[g] = (dly_deg < lo_deg) || (dly_deg > hi_deg);
    end
  end

  // ----------------------------------------
  // Totalizers and error counters
  // ----------------------------------------
  wire [4:0] dual;

  // Dual checking only while both inputs of the group are alive
  assign dual = dual_mode & {alive_r[8], alive_r[6], alive_r[4],
                             alive_r[2], alive_r[0]} &
                {alive_r[9], alive_r[7], alive_r[5], alive_r[3],
                 alive_r[1]};

  // Count runs free of host access; dual pairs checked per group
  always @(posedge clk) begin : total_proc
    integer g;
    for (g = 0; g < 5; g = g + 1) begin
      if (!resetn) begin
        total[(2*g)*16 +: 16] <= `TOTAL_RST;
        total[(2*g+1)*16 +: 16] <= `TOTAL_RST;
        seq_err_cnt[g*16 +: 16] <= `TOTAL_RST;
        coinc_err_cnt[g*16 +: 16] <= `TOTAL_RST;
        phase_err_cnt[g*16 +: 16] <= `TOTAL_RST;
        extra_err_cnt[g*16 +: 16] <= `TOTAL_RST;
        a_pend_r[g] <= 1'b0;
        dly_r[g] <= `PERIOD_RST;
      end else if (!dual[g]) begin
        // Single mode or one signal lost: plain counting
        if (rise[2*g])
          total[(2*g)*16 +: 16] <=
            total[(2*g)*16 +: 16] + 16'h0001;
        if (rise[2*g+1])
          total[(2*g+1)*16 +: 16] <=
            total[(2*g+1)*16 +: 16] + 16'h0001;
        a_pend_r[g] <= 1'b0;
        dly_r[g] <= `PERIOD_RST;
      end else if (rise[2*g] && rise[2*g+1]) begin
        coinc_err_cnt[g*16 +: 16] <=
          coinc_err_cnt[g*16 +: 16] + 16'h0001;
        a_pend_r[g] <= 1'b0;
      end else if (rise[2*g]) begin
        if (a_pend_r[g])
          extra_err_cnt[g*16 +: 16] <=
            extra_err_cnt[g*16 +: 16] + 16'h0001;
        a_pend_r[g] <= 1'b1;
        dly_r[g] <= `PERIOD_RST;
      end else if (rise[2*g+1]) begin
        a_pend_r[g] <= 1'b0;
        if (!a_pend_r[g])
          seq_err_cnt[g*16 +: 16] <=
            seq_err_cnt[g*16 +: 16] + 16'h0001;
        else if (coinc[g])
          coinc_err_cnt[g*16 +: 16] <=
            coinc_err_cnt[g*16 +: 16] + 16'h0001;
        else if (phase_bad[g])
          phase_err_cnt[g*16 +: 16] <=
            phase_err_cnt[g*16 +: 16] + 16'h0001;
        else begin
          total[(2*g)*16 +: 16] <=
            total[(2*g)*16 +: 16] + 16'h0001;
          total[(2*g+1)*16 +: 16] <=
            total[(2*g+1)*16 +: 16] + 16'h0001;
        end
      end else if (a_pend_r[g] && dly_r[g] <= MAX_P) begin
        dly_r[g] <= dly_r[g] + 26'h0000001;
      end
    end
  end

  // ----------------------------------------
  // Host watchdog and blink timer
  // ----------------------------------------
  reg [27:0] host_cnt_r;
  reg host_ok_r;
  reg [25:0] blink_cnt_r;
  reg blink_r;

  // Host access restarts the watchdog; blink toggles each half period
  always @(posedge clk) begin
    if (!resetn) begin
      host_cnt_r <= 28'h0000000;
      host_ok_r <= 1'b0;
      blink_cnt_r <= 26'h0000000;
      blink_r <= 1'b0;
    end else begin
      if (host_access) begin
        host_cnt_r <= 28'h0000000;
        host_ok_r <= 1'b1;
      end else if (host_cnt_r >= HOST_TO - 28'h0000001) begin
        host_ok_r <= 1'b0;
      end else begin
        host_cnt_r <= host_cnt_r + 28'h0000001;
      end
      if (blink_cnt_r >= BLINK_H - 26'h0000001) begin
        blink_cnt_r <= 26'h0000000;
        blink_r <= ~blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 26'h0000001;
      end
    end
  end

  // ----------------------------------------
  // Indicators, prover port and identifier
  // ----------------------------------------
  wire [31:0] min_width_full;
  wire [25:0] min_width;
  reg [39:0] cls;
  wire pwr_ok;
  wire hs_ok;
  wire init_ok;

  assign min_width_full = (high_freq_limit / `DUTY_MIN_DEN) * `DUTY_MIN_NUM;
  assign min_width = min_width_full[25:0];
  assign init_ok = sync2_r[13];
  assign pwr_ok = sync2_r[14];
  assign hs_ok = sync2_r[15];

  // Class of each input from its latest measurements
  always @* begin : class_proc
    integer c;
    c = 0;
    cls = 40'h0;
    for (c = 0; c < 10; c = c + 1)
      cls[4*c +: 4] = classify(input_enable[c], alive_r[c],
                               period[c*26 +: 26], hi_r[c],
                               low_freq_limit, high_freq_limit,
                               min_width);
  end

  // All front lights and discrete outputs registered
  always @(posedge clk) begin : led_proc
    integer k;
    if (!resetn) begin
      power_led_green <= 1'b0;
      power_led_red <= 1'b0;
      host_led_green <= 1'b0;
      host_led_red <= 1'b0;
      proving_indicator <= 1'b0;
      fail_led_red <= 1'b0;
      input_led_green <= 10'h000;
      input_led_red <= 10'h000;
      prover_run_output <= 1'b0;
      prover_run_oe_n <= 1'b1;
      prover_in_state <= 3'h0;
      module_identifier <= 8'h00;
    end else begin
      power_led_green <= pwr_ok & hs_ok & init_ok;
      power_led_red <= pwr_ok & hs_ok & ~init_ok;
      host_led_green <= host_ok_r;
      host_led_red <= ~host_ok_r;
      proving_indicator <= proving_active;
      fail_led_red <= bus_fail;
      for (k = 0; k < 10; k = k + 1) begin
        case (cls[4*k +: 4])
          CL_OFF: begin
            input_led_green[k] <= 1'b0;
            input_led_red[k] <= 1'b0;
          end
          CL_GREEN: begin
            input_led_green[k] <= 1'b1;
            input_led_red[k] <= 1'b0;
          end
          CL_BLINK: begin
            input_led_green[k] <= blink_r;
            input_led_red[k] <= 1'b0;
          end
          CL_RED: begin
            input_led_green[k] <= 1'b0;
            input_led_red[k] <= 1'b1;
          end
          default: begin
            input_led_green[k] <= 1'b0;
            input_led_red[k] <= 1'b1;
          end
        endcase
      end
      // Open drain pulls low while the run command holds
      prover_run_output <= 1'b0;
      prover_run_oe_n <= ~prover_run_cmd;
      prover_in_state <= deb_r[12:10];
      module_identifier <= `MODULE_IDENTIFIER_VALUE;
    end
  end

endmodule

// >>> verif/pulse_status_checker.sv
// Concurrent checks on the pulse status block's top ports.
// Assumes one clock domain and a bind from the bench's top file.
`timescale 1ns/1ps
`include "pulse_input_status_defines.vh"
module pulse_status_checker #(
  parameter HOST_TIMEOUT = 500
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Controls and pins
  input wire bus_power_ok,
  input wire hot_swap_ok,
  input wire init_done,
  input wire host_access,
  input wire bus_fail,
  input wire proving_active,
  input wire prover_run_cmd,
  input wire [9:0] input_enable,
  // Watched outputs
  input wire [159:0] total,
  input wire [7:0] module_identifier,
  input wire prover_run_output,
  input wire prover_run_oe_n,
  input wire power_led_green,
  input wire power_led_red,
  input wire host_led_green,
  input wire host_led_red,
  input wire proving_indicator,
  input wire fail_led_red,
  input wire [9:0] input_led_green,
  input wire [9:0] input_led_red
);
  localparam int LIM = HOST_TIMEOUT + 3;
  reg [31:0] idle_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Cycles since the last host read, saturating
  always @(posedge clk) begin
    if (!resetn || host_access) idle_r <= 32'h0;
    else if (idle_r < LIM) idle_r <= idle_r + 32'h1;
  end

  // ----------------------------------------
  // Power pin mixes held long enough to pass the sync
  // ----------------------------------------
  sequence all_ok_s;
    (bus_power_ok && hot_swap_ok && init_done) [*4];
  endsequence
  sequence no_init_s;
    (bus_power_ok && hot_swap_ok && !init_done) [*4];
  endsequence
  sequence no_pwr_s;
    (!bus_power_ok || !hot_swap_ok) [*4];
  endsequence

  a_power_green: assert property (all_ok_s |-> power_led_green)
    else $error("power light not green");
  a_power_red: assert property (no_init_s |-> power_led_red)
    else $error("power light not red");
  a_power_off: assert property (no_pwr_s |->
    !power_led_green && !power_led_red) else $error("power light lit");
  a_host_green: assert property (host_access |-> ##2
    host_led_green && !host_led_red) else $error("host light not green");
  a_host_red: assert property (idle_r >= LIM |->
    host_led_red && !host_led_green) else $error("host light not red");
  a_proving_indicator_follow: assert property (
    proving_indicator == $past(proving_active))
    else $error("proving light wrong");
  a_fail_follow: assert property (
    fail_led_red == $past(bus_fail)) else $error("fail light wrong");
  a_run_drive: assert property (prover_run_output == 1'b0 &&
    prover_run_oe_n == !$past(prover_run_cmd))
    else $error("prover output wrong");
  a_input_off: assert property ((~input_enable &
    ~$past(input_enable) & (input_led_green | input_led_red)) == 10'h0)
    else $error("disabled input light lit");
  a_id_fixed: assert property ($past(resetn) |->
    module_identifier == `MODULE_IDENTIFIER_VALUE) else $error("id wrong");
  genvar g;
  for (g = 0; g < 10; g++) begin : per_in
    a_total_step: assert property ($changed(total[16*g+:16]) |->
      total[16*g+:16] == $past(total[16*g+:16]) + 16'h1)
      else $error("total moved by other than one");
  end
endmodule

// >>> verif/pulse_source.sv
// Pulse transmitter and prover detector model for the status block.
// Assumes the bench calls its tasks; pins are driven low when idle.
`timescale 1ns/1ps
module pulse_source (
  // Clock
  input wire clk,
  // Field pins
  output reg [9:0] pins,
  output reg [2:0] det
);
  initial begin
    pins = 10'h000;
    det = 3'h0;
  end

  // A on even pins, B dly cycles later on odd pins
  task burst(input int n, input int per, input int hi, input int dly);
    int k;
    logic a;
    logic b;
    for (k = 0; k < n * per + dly; k++) begin
      a = k < n * per && k % per < hi;
      b = k >= dly && k - dly < n * per && (k - dly) % per < hi;
      @(posedge clk);
      #1 pins = {5{b, a}};
    end
    @(posedge clk);
    #1 pins = 10'h000;
  endtask

  // Detector levels change just after an edge
  task set_det(input logic [2:0] v);
    @(posedge clk);
    #1 det = v;
  endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the pulse status block.
// Assumes the checker and pulse source model are compiled first.
`timescale 1ns/1ps
`include "pulse_input_status_defines.vh"
bind pulse_input_status_counter pulse_status_checker #(
  .HOST_TIMEOUT(HOST_TIMEOUT)) chk_i (.clk(clk), .resetn(resetn),
  .bus_power_ok(bus_power_ok), .hot_swap_ok(hot_swap_ok),
  .init_done(init_done), .host_access(host_access), .bus_fail(bus_fail),
  .proving_active(proving_active), .prover_run_cmd(prover_run_cmd),
  .input_enable(input_enable), .total(total),
  .module_identifier(module_identifier),
  .prover_run_output(prover_run_output),
  .prover_run_oe_n(prover_run_oe_n), .power_led_green(power_led_green),
  .power_led_red(power_led_red), .host_led_green(host_led_green),
  .host_led_red(host_led_red), .proving_indicator(proving_indicator),
  .fail_led_red(fail_led_red), .input_led_green(input_led_green),
  .input_led_red(input_led_red));
module testbench;
  localparam int HT = 500;
  localparam int BH = 50;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg bus_power_ok = 1'b1, hot_swap_ok = 1'b1, init_done = 1'b1;
  reg host_access = 1'b0, bus_fail = 1'b0, proving_active = 1'b0;
  reg prover_run_cmd = 1'b0;
  reg [9:0] input_enable = 10'h3ff;
  reg [4:0] dual_mode = 5'h00;
  reg [25:0] low_freq_limit = 26'h5dc, high_freq_limit = 26'h1f4;
  reg [8:0] phase_dif = 9'h05a, phase_dev = 9'h014;
  wire [9:0] pulse_in, input_led_green, input_led_red;
  wire [2:0] prover_discrete_input, prover_in_state;
  wire [159:0] total;
  wire [79:0] phase_err_cnt, seq_err_cnt, coinc_err_cnt, extra_err_cnt;
  wire [259:0] period;
  wire [7:0] module_identifier;
  wire prover_run_output, prover_run_oe_n, power_led_green, power_led_red;
  wire host_led_green, host_led_red, proving_indicator, fail_led_red;
  wire run_line = prover_run_oe_n ? 1'b1 : prover_run_output; // Pull-up
  int num_errors = 0, n_checks = 0, cyc = 0, k, i;
  logic [15:0] exp_tot [10];
  logic [9:0] g;

  pulse_input_status_counter #(.MAX_PERIOD(2000), .MIN_PERIOD(100),
    .HOST_TIMEOUT(HT), .BLINK_HALF(BH)) uut (.clk(clk), .resetn(resetn),
    .pulse_in(pulse_in), .prover_discrete_input(prover_discrete_input),
    .prover_run_output(prover_run_output),
    .prover_run_oe_n(prover_run_oe_n), .bus_power_ok(bus_power_ok),
    .hot_swap_ok(hot_swap_ok), .init_done(init_done),
    .host_access(host_access), .bus_fail(bus_fail),
    .proving_active(proving_active), .prover_run_cmd(prover_run_cmd),
    .input_enable(input_enable), .dual_mode(dual_mode),
    .low_freq_limit(low_freq_limit), .high_freq_limit(high_freq_limit),
    .phase_dif(phase_dif), .phase_dev(phase_dev), .total(total),
    .period(period), .seq_err_cnt(seq_err_cnt),
    .coinc_err_cnt(coinc_err_cnt),
    .phase_err_cnt(phase_err_cnt), .extra_err_cnt(extra_err_cnt),
    .prover_in_state(prover_in_state),
    .module_identifier(module_identifier),
    .power_led_green(power_led_green), .power_led_red(power_led_red),
    .host_led_green(host_led_green), .host_led_red(host_led_red),
    .proving_indicator(proving_indicator), .fail_led_red(fail_led_red),
    .input_led_green(input_led_green), .input_led_red(input_led_red));
  pulse_source src (.clk(clk), .pins(pulse_in),
    .det(prover_discrete_input));

  // ----------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks = n_checks + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task run(input int n, input int per, input int hi, input int dly,
           input logic [9:0] m);
    src.burst(n, per, hi, dly);
    for (i = 0; i < 10; i++) if (m[i]) exp_tot[i] = exp_tot[i] + n;
  endtask
  task cmp_tot;
    for (i = 0; i < 10; i++) if (i != 3) chk(total[16*i+:16], exp_tot[i]);
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    for (i = 0; i < 10; i++) exp_tot[i] = 16'h0000;
    step(20);
    resetn = 1'b1;
    for (k = 0; k < 8; k++) begin
      {bus_power_ok, hot_swap_ok, init_done} = k[2:0];
      step(5);
      chk(power_led_green, k == 7);
      chk(power_led_red, k == 6);
      chk(power_led_green | power_led_red, k >= 6);
    end
    $display("power test done");
    {proving_active, bus_fail, prover_run_cmd} = 3'h7;
    src.set_det(3'h5);
    step(270);
    chk({proving_indicator, fail_led_red, run_line}, 3'h6);
    chk(prover_in_state, 3'h5);
    {proving_active, bus_fail, prover_run_cmd} = 3'h0;
    step(2);
    chk({proving_indicator, fail_led_red, run_line}, 3'h1);
    chk(module_identifier, `MODULE_IDENTIFIER_VALUE);
    host_access = 1'b1;
    step(1);
    host_access = 1'b0;
    step(2);
    chk({host_led_green, host_led_red}, 2'h2);
    step(HT + 5);
    chk({host_led_green, host_led_red}, 2'h1);
    $display("lights test done");
    input_enable = 10'h3f7;
    run(5, 1000, 300, 0, 10'h3ff);
    chk(host_led_red, 1'b1);
    cmp_tot;
    chk(period[25:0], 26'h3e8);
    chk(input_led_green, 10'h3f7);
    chk(input_led_red, 10'h000);
    input_enable = 10'h3ff;
    low_freq_limit = 26'h320;
    run(4, 1000, 300, 0, 10'h3ff);
    g = input_led_green;
    step(BH);
    chk(g ^ input_led_green, 10'h3ff);
    chk(input_led_red, 10'h000);
    $display("count test done");
    low_freq_limit = 26'h5dc;
    high_freq_limit = 26'h834;
    run(3, 1000, 300, 0, 10'h3ff);
    chk(input_led_red, 10'h3ff);
    high_freq_limit = 26'h1f4;
    step(2);
    chk(input_led_red, 10'h000);
    step(2500);
    chk(input_led_red, 10'h3ff);
    run(3, 1000, 100, 0, 10'h000);
    cmp_tot;
    $display("range test done");
    run(3, 1000, 400, 250, 10'h3ff);
    dual_mode = 5'h01;
    run(4, 1000, 400, 250, 10'h3ff);
    run(4, 1000, 400, 500, 10'h3fc);
    cmp_tot;
    chk(phase_err_cnt[15:0], 16'h0004);
    run(3, 1000, 400, 0, 10'h3fc);
    run(2, 600, 300, 700, 10'h3fc);
    cmp_tot;
    chk(coinc_err_cnt[15:0], 16'h0003);
    chk(phase_err_cnt[15:0], 16'h0005);
    chk(extra_err_cnt[15:0], 16'h0001);
    chk(seq_err_cnt[15:0], 16'h0001);
    $display("dual test done");
    final_report;
  end
endmodule
